// ### strap_mode_ctrl.sv
// Purpose: strap mode decode, calibration sequencing and status over AXI4-Lite
// Assumes: aclk stands for the converter input clock; pins arrive asynchronously
// Notes: mode flags are frozen one cycle after reset release
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
`include "strap_params.svh"
module strap_mode_ctrl #(
    parameter int unsigned DLY_SHORT = `DLY_SHORT_CYC,    // short power-up delay
    parameter int unsigned DLY_LONG = `DLY_LONG_CYC,      // long power-up delay
    parameter int unsigned CAL_RUN = `CAL_RUN_CYC,        // calibration length
    parameter int unsigned CAL_LOW_MIN = `CAL_LOW_MIN_CYC, // trigger low minimum
    parameter int unsigned CAL_HIGH_MIN = `CAL_HIGH_MIN_CYC // trigger high minimum
) (
    input wire logic aclk,            // block clock
    input wire logic aresetn,         // synchronous reset, active low
    input wire logic [7:0] awaddr,    // write address
    input wire logic [2:0] awprot,    // write protection, unused
    input wire logic awvalid,         // write address valid
    output logic awready,             // write address ready
    input wire logic [31:0] wdata,    // write data
    input wire logic [3:0] wstrb,     // write byte enables
    input wire logic wvalid,          // write data valid
    output logic wready,              // write data ready
    output logic [1:0] bresp,         // write response
    output logic bvalid,              // write response valid
    input wire logic bready,          // write response ready
    input wire logic [7:0] araddr,    // read address
    input wire logic [2:0] arprot,    // read protection, unused
    input wire logic arvalid,         // read address valid
    output logic arready,             // read address ready
    output logic [31:0] rdata,        // read data
    output logic [1:0] rresp,         // read response
    output logic rvalid,              // read data valid
    input wire logic rready,          // read data ready
    input wire logic strap_hi_pin,    // strap pin above upper threshold
    input wire logic strap_lo_pin,    // strap pin below lower threshold
    input wire logic range_hi_pin,    // range pin above upper threshold
    input wire logic range_lo_pin,    // range pin below lower threshold
    input wire logic cal_trigger_pin, // calibration trigger pin
    input wire logic clk_pos_pin,     // positive leg of converter clock
    output logic cal_running_flag,    // calibration in progress
    output logic cal_delay_select,    // long power-up delay chosen
    output logic serial_chip_select,  // serial interface selected
    output logic ext_ctrl_mode,       // extended control active
    output logic des_mode,            // dual edge sampling active
    output logic range_high,          // high full-scale range
    output logic sample_i_en,         // capture pulse for I
    output logic sample_q_en,         // capture pulse for Q
    output logic irq                  // level interrupt
);
    localparam int CNT_W = 16; // wide enough for the long delay

    // =================================================================
    // pin synchronisers and level decode
    logic [5:0] pins_s; // synchronised pins
    strap_pkg::strap_level_e strap_lvl; // live strap level
    strap_pkg::strap_level_e range_lvl; // live range level

    pin_sync #(.W(6)) u_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .d({clk_pos_pin, cal_trigger_pin, range_lo_pin, range_hi_pin, strap_lo_pin, strap_hi_pin}),
        .q(pins_s)
    );

    tri_level_decode u_strap_dec (
        .hi(pins_s[0]),
        .lo(pins_s[1]),
        .lvl(strap_lvl)
    );

    tri_level_decode u_range_dec (
        .hi(pins_s[2]),
        .lo(pins_s[3]),
        .lvl(range_lvl)
    );

    wire trig_s = pins_s[4]; // trigger level
    wire clk_s = pins_s[5];  // converter clock level

    // =================================================================
    // mode decode from live levels, frozen at boot; chip select stays live
    strap_pkg::mode_flags_s flags;      // frozen flags
    strap_pkg::mode_flags_s live_flags; // decode of live levels
    strap_pkg::cal_state_e state;       // sequencer state
    strap_pkg::strap_level_e strap_cap; // strap level at boot
    strap_pkg::strap_level_e range_cap; // range level at boot

    assign live_flags.ext_mode = (range_lvl == strap_pkg::LVL_MID);
    assign live_flags.range_high = (range_lvl == strap_pkg::LVL_HIGH);
    assign live_flags.des_mode = (strap_lvl == strap_pkg::LVL_MID);
    // a floating range pin leaves only the short delay
    assign live_flags.cal_dly = !live_flags.ext_mode && (strap_lvl == strap_pkg::LVL_HIGH);

    wire booting = (state == strap_pkg::CAL_BOOT); // first cycle after reset
    wire moved = !booting && ((strap_lvl != strap_cap) || (range_lvl != range_cap));

    // capture once; later pin moves raise an event and leave the captured flags alone
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags <= '0;
            strap_cap <= strap_pkg::LVL_LOW;
            range_cap <= strap_pkg::LVL_LOW;
        end
        else if (booting)
        begin
            flags <= live_flags;
            strap_cap <= strap_lvl;
            range_cap <= range_lvl;
        end
    end

    assign ext_ctrl_mode = flags.ext_mode;
    assign des_mode = flags.des_mode;
    assign cal_delay_select = flags.cal_dly;
    assign range_high = flags.range_high;

    // chip select is live: the host frames each transfer with it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            serial_chip_select <= 1'b0;
        else
            serial_chip_select <= flags.ext_mode && (strap_lvl == strap_pkg::LVL_LOW);
    end

    // =================================================================
    // sample strobes from the converter clock
    logic clk_d; // previous clock level
    wire clk_fall = clk_d && !clk_s;
    wire clk_rise = !clk_d && clk_s;

    // dual edge uses both edges for I and starves Q
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_d <= clk_s; // idle level, so no false edge at release
            sample_i_en <= 1'b0;
            sample_q_en <= 1'b0;
        end
        else
        begin
            clk_d <= clk_s;
            sample_i_en <= clk_fall || (flags.des_mode && clk_rise);
            sample_q_en <= clk_fall && !flags.des_mode;
        end
    end

    // =================================================================
    // calibration trigger: low phase then high phase
    logic [CNT_W-1:0] low_cnt;  // saturating low count
    logic [CNT_W-1:0] high_cnt; // high count after low phase
    wire low_met = (low_cnt == CNT_W'(CAL_LOW_MIN));
    wire trig_go = trig_s && low_met && (high_cnt == CNT_W'(CAL_HIGH_MIN - 1));

    // a high glitch before the low minimum restarts the low phase
    always_ff @(posedge aclk)
    begin
        if (!aresetn || trig_go)
        begin
            low_cnt <= '0;
            high_cnt <= '0;
        end
        else if (!trig_s)
        begin
            low_cnt <= low_met ? low_cnt : low_cnt + 1'b1;
            high_cnt <= '0;
        end
        else if (!low_met)
            low_cnt <= '0;
        else
            high_cnt <= high_cnt + 1'b1;
    end

    // =================================================================
    // calibration sequencer
    logic [CNT_W-1:0] cnt;  // delay and run counter
    logic sw_go;            // software request pulse
    wire [CNT_W-1:0] dly_end = flags.cal_dly ? CNT_W'(DLY_LONG - 1) : CNT_W'(DLY_SHORT - 1);
    wire wait_done = (state == strap_pkg::CAL_WAIT) && (cnt == dly_end);
    wire run_done = (state == strap_pkg::CAL_RUN) && (cnt == CNT_W'(CAL_RUN - 1));
    wire cmd_go = (state == strap_pkg::CAL_IDLE) && (trig_go || sw_go);
    wire cal_start = wait_done || cmd_go;

    // requests during a calibration are dropped, not queued
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= strap_pkg::CAL_BOOT;
            cnt <= '0;
        end
        else
        begin
            case (state)
                strap_pkg::CAL_BOOT:
                    state <= strap_pkg::CAL_WAIT;
                strap_pkg::CAL_WAIT:
                    cnt <= wait_done ? '0 : cnt + 1'b1;
                strap_pkg::CAL_RUN:
                    cnt <= run_done ? '0 : cnt + 1'b1;
                strap_pkg::CAL_IDLE:
                    cnt <= '0;
                default:
                    state <= strap_pkg::CAL_BOOT;
            endcase
            if (cal_start)
                state <= strap_pkg::CAL_RUN;
            else if (run_done)
                state <= strap_pkg::CAL_IDLE;
        end
    end

    assign cal_running_flag = (state == strap_pkg::CAL_RUN);

    // =================================================================
    // AXI4-Lite write channel
    logic aw_hold;         // address taken
    logic w_hold;          // data taken
    logic [7:0] awaddr_q;  // held address
    logic [31:0] wdata_q;  // held data
    logic [3:0] wstrb_q;   // held strobes
    wire wr_go = aw_hold && w_hold && !bvalid;
    wire wr_ctrl = wr_go && (awaddr_q == `OFS_CTRL);
    wire wr_mask = wr_go && (awaddr_q == `OFS_IRQ_MASK);
    wire wr_ok = (awaddr_q == `OFS_CTRL) || (awaddr_q == `OFS_STATUS) ||
                 (awaddr_q == `OFS_IRQ_STAT) || (awaddr_q == `OFS_IRQ_MASK);

    assign awready = !aw_hold;
    assign wready = !w_hold;

    // address and data may arrive in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_hold <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_hold <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bready)
                bvalid <= 1'b0;
        end
    end

    // control writes only count in extended control mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sw_go <= 1'b0;
        else
            sw_go <= wr_ctrl && wstrb_q[0] && wdata_q[`CTRL_CAL_BIT] && flags.ext_mode;
    end

    // =================================================================
    // interrupt status, read to clear, set wins
    logic [`IRQ_W-1:0] irq_stat; // sticky events
    logic [`IRQ_W-1:0] irq_mask; // enables
    logic [`IRQ_W-1:0] irq_set;  // this cycle's events
    wire ar_fire = arvalid && arready;
    wire rd_irq = ar_fire && (araddr == `OFS_IRQ_STAT);

    assign irq_set[`IRQ_DONE_BIT] = run_done;
    assign irq_set[`IRQ_START_BIT] = cal_start;
    assign irq_set[`IRQ_MOVED_BIT] = moved;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat <= '0;
            irq_mask <= `IRQ_MASK_RST;
        end
        else
        begin
            irq_stat <= (rd_irq ? '0 : irq_stat) | irq_set;
            if (wr_mask && wstrb_q[0])
                irq_mask <= wdata_q[`IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // =================================================================
    // AXI4-Lite read channel
    logic [31:0] rd_mux; // selected word
    wire [5:0] status_bits = {serial_chip_select, cal_running_flag, flags.range_high,
                              flags.cal_dly, flags.des_mode, flags.ext_mode};
    wire rd_ok = (araddr == `OFS_CTRL) || (araddr == `OFS_STATUS) ||
                 (araddr == `OFS_IRQ_STAT) || (araddr == `OFS_IRQ_MASK);

    assign arready = !rvalid;
    assign rd_mux = (araddr == `OFS_STATUS) ? {26'h0, status_bits} :
                    (araddr == `OFS_IRQ_STAT) ? {29'h0, irq_stat} :
                    (araddr == `OFS_IRQ_MASK) ? {29'h0, irq_mask} : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // =================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_dly_firm;
        !flags.ext_mode && !booting |-> flags.cal_dly == (strap_cap == strap_pkg::LVL_HIGH);
    endproperty
    a_dly_firm: assert property (p_dly_firm) else $error("delay select not from strap");

    property p_cs_live;
        serial_chip_select |-> $past(flags.ext_mode) && $past(strap_lvl) == strap_pkg::LVL_LOW;
    endproperty
    a_cs_live: assert property (p_cs_live) else $error("chip select without cause");

    property p_dly_zero;
        flags.ext_mode |-> !cal_delay_select;
    endproperty
    a_dly_zero: assert property (p_dly_zero) else $error("delay not forced short");

    property p_des;
        !booting |-> des_mode == (strap_cap == strap_pkg::LVL_MID);
    endproperty
    a_des: assert property (p_des) else $error("dual edge mode wrong");

    sequence s_rise_des;
        des_mode && clk_rise;
    endsequence
    property p_des_i;
        s_rise_des |=> sample_i_en && !sample_q_en;
    endproperty
    a_des_i: assert property (p_des_i) else $error("dual edge I pulse missing");

    property p_fall;
        clk_fall |=> sample_i_en;
    endproperty
    a_fall: assert property (p_fall) else $error("no sample on falling edge");

    property p_run_len;
        $rose(cal_running_flag) |-> cal_running_flag [*8];
    endproperty
    a_run_len: assert property (p_run_len) else $error("calibration ended early");

    property p_run_cause;
        $rose(cal_running_flag) |-> $past(wait_done) || $past(trig_go) || $past(sw_go);
    endproperty
    a_run_cause: assert property (p_run_cause) else $error("calibration without cause");

    property p_trig;
        trig_go |-> $past(trig_s) && low_met;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger without low phase");

    property p_sw;
        sw_go |-> flags.ext_mode;
    endproperty
    a_sw: assert property (p_sw) else $error("command outside extended mode");

    property p_stable;
        !booting && !$past(booting) |-> $stable(flags);
    endproperty
    a_stable: assert property (p_stable) else $error("mode flags moved");
endmodule

// ### strap_params.svh
// Purpose: offsets, field positions, reset values and cycle counts of the strap block
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH

// =====================================================================
// register offsets (byte addresses, one word each)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C

// =====================================================================
// field positions
`define CTRL_CAL_BIT 0
`define ST_EXT_BIT 0
`define ST_DES_BIT 1
`define ST_DLY_BIT 2
`define ST_RANGE_BIT 3
`define ST_RUN_BIT 4
`define ST_CS_BIT 5
`define IRQ_DONE_BIT 0
`define IRQ_START_BIT 1
`define IRQ_MOVED_BIT 2
`define IRQ_W 3

// =====================================================================
// reset values and bus answers
`define IRQ_MASK_RST 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// =====================================================================
// cycle counts of the converter input clock
`define DLY_SHORT_CYC 256
`define DLY_LONG_CYC 8192
`define CAL_RUN_CYC 1024
`define CAL_LOW_MIN_CYC 80
`define CAL_HIGH_MIN_CYC 80

`endif

// ### strap_pkg.sv
// Purpose: types shared by the strap decode block
// Assumes: nothing
// Notes: constants live in strap_params.svh
package strap_pkg;

    // resolved level of a three-level pin
    typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_MID} strap_level_e;

    // calibration sequencer states
    typedef enum logic [1:0] {CAL_BOOT, CAL_WAIT, CAL_RUN, CAL_IDLE} cal_state_e;

    // mode flags captured once after reset
    typedef struct packed {
        logic ext_mode;   // extended control active
        logic des_mode;   // dual edge sampling
        logic cal_dly;    // long power-up delay
        logic range_high; // high full-scale range
    } mode_flags_s;

endpackage

// ### pin_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: one bit per pin, no multi-bit coherence needed
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,         // block clock
    input wire logic rst_n,       // reset input, unused: the flops have no reset
    input wire logic [W-1:0] d,   // raw pin levels
    output logic [W-1:0] q        // synchronised levels
);
    // =================================================================
    // one pair of flops per pin
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic meta; // metastability catcher
            // no reset: the pair keeps sampling so levels are fresh at release
            always_ff @(posedge clk)
            begin
                meta <= d[i];
                q[i] <= meta;
            end
        end
    endgenerate
endmodule

// ### tri_level_decode.sv
// Purpose: resolve a three-level pin from its two comparator outputs
// Assumes: hi is above two thirds of supply, lo below one third
// Notes: both set cannot happen on a sane pad; treated as mid
`timescale 1ns/100ps
module tri_level_decode (
    input wire logic hi,                 // level above upper threshold
    input wire logic lo,                 // level below lower threshold
    output strap_pkg::strap_level_e lvl  // resolved level
);
    // =================================================================
    // neither comparator set means floating or half supply
    assign lvl = (hi && !lo) ? strap_pkg::LVL_HIGH :
                 (lo && !hi) ? strap_pkg::LVL_LOW : strap_pkg::LVL_MID;
endmodule

// ### strap_board.sv
// Purpose: board side of the strap block: strap wiring, trigger pin, converter clock
// Assumes: every task is entered just after a rising edge of aclk
// Notes: the converter clock idles high and runs only on request
`timescale 1ns/100ps
module strap_board (
    input wire logic aclk,                // bench clock
    input strap_pkg::strap_level_e strap_lvl, // wanted strap level
    input strap_pkg::strap_level_e range_lvl, // wanted range pin level
    output logic strap_hi_pin,            // strap above upper threshold
    output logic strap_lo_pin,            // strap below lower threshold
    output logic range_hi_pin,            // range above upper threshold
    output logic range_lo_pin,            // range below lower threshold
    output logic cal_trigger_pin,         // trigger, idles high
    output logic clk_pos_pin              // converter clock positive leg
);
    // ==========================================
    // comparators: a floating pin trips neither
    assign strap_hi_pin = (strap_lvl == strap_pkg::LVL_HIGH);
    assign strap_lo_pin = (strap_lvl == strap_pkg::LVL_LOW);
    assign range_hi_pin = (range_lvl == strap_pkg::LVL_HIGH);
    assign range_lo_pin = (range_lvl == strap_pkg::LVL_LOW);

    // ==========================================
    // idle levels at time zero
    initial
    begin
        cal_trigger_pin = 1'b1;
        clk_pos_pin = 1'b1;
    end

    // low phase then high phase; counts below the minimum are for refusal tests
    task automatic pulse_trigger(input int lo, input int hi);
        cal_trigger_pin <= 1'b0;
        repeat (lo) @(posedge aclk);
        cal_trigger_pin <= 1'b1;
        repeat (hi) @(posedge aclk);
    endtask

    // slow clock so the two sync flops see every edge
    task automatic run_clock(input int k);
        repeat (k)
        begin
            clk_pos_pin <= 1'b0;
            repeat (4) @(posedge aclk);
            clk_pos_pin <= 1'b1;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule

// ### strap_mode_ctrl_tb_top.sv
// Purpose: self-checking bench of the strap decode block
// Assumes: short counts set by parameter; bus tasks start after a rising edge
// Notes: bus answers are queued by the tasks and compared by the monitor
`timescale 1ns/100ps
`include "strap_params.svh"
module strap_mode_ctrl_tb_top;
    localparam int unsigned D_SHORT = 4, D_LONG = 8, C_RUN = 10, C_LOW = 3, C_HIGH = 3;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot = 3'h0, arprot = 3'h0; // protection is ignored
    logic [31:0] wdata, rdata, rnd;
    logic [3:0] wstrb = 4'hF; // only byte 0 matters
    logic [1:0] bresp, rresp;
    logic strap_hi_pin, strap_lo_pin, range_hi_pin, range_lo_pin, cal_trigger_pin, clk_pos_pin;
    logic cal_running_flag, cal_delay_select, serial_chip_select, ext_ctrl_mode, des_mode, range_high;
    logic sample_i_en, sample_q_en, irq;
    strap_pkg::strap_level_e strap_lvl, range_lvl;
    int err_count, n_compared, cyc, since, run_len, rise_cyc, ni, nq, seed, k, rise_at [4];
    logic [34:0] exp_r [$], ent; // care bit, response, data
    logic [1:0] exp_b [$];
    // mode table: range level, strap level, expected {ext, des, dly, range, cs}
    strap_pkg::strap_level_e t_rng [4] = '{strap_pkg::LVL_HIGH, strap_pkg::LVL_MID, strap_pkg::LVL_LOW, strap_pkg::LVL_MID};
    strap_pkg::strap_level_e t_str [4] = '{strap_pkg::LVL_HIGH, strap_pkg::LVL_LOW, strap_pkg::LVL_MID, strap_pkg::LVL_HIGH};
    logic [4:0] t_exp [4] = '{5'b00110, 5'b10001, 5'b01000, 5'b10000};

    strap_mode_ctrl #(.DLY_SHORT(D_SHORT), .DLY_LONG(D_LONG), .CAL_RUN(C_RUN), .CAL_LOW_MIN(C_LOW),
        .CAL_HIGH_MIN(C_HIGH)) u_dut (.*);
    strap_board u_board (.*);

    // ==========================================
    // clock, 100 ns period
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ==========================================
    // shared compare and closing
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
            $display("wrong value at %0t: saw %0h, wanted %0h", $time, got, exp);
        if (got !== exp)
            err_count++;
    endtask

    task automatic give_verdict;
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // wait on a flag sampled mid-cycle, so no edge race
    task automatic wait_run(input logic v);
        int n;
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end while (cal_running_flag !== v && n < 100);
        check(cal_running_flag, v);
        @(posedge aclk);
    endtask

    // ==========================================
    // AXI4-Lite master tasks
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_t, w_t, b_t;
        exp_b.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_t = 1'b0;
        while (awvalid | wvalid | !b_t)
        begin
            @(negedge aclk);
            aw_t = (awready === 1'b1) & awvalid;
            w_t = (wready === 1'b1) & wvalid;
            b_t = (bvalid === 1'b1);
            @(posedge aclk);
            if (aw_t)
                awvalid <= 1'b0;
            if (w_t)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input logic care);
        logic t;
        exp_r.push_back({care, r, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 1'b0;
        while (!t)
        begin
            @(negedge aclk);
            t = (arready === 1'b1);
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        t = 1'b0;
        while (!t)
        begin
            @(negedge aclk);
            t = (rvalid === 1'b1);
            @(posedge aclk);
        end
        rready <= 1'b0;
    endtask

    // ==========================================
    // monitor: bus answers, capture pulses, calibration length, timeout
    always @(posedge aclk)
    begin
        cyc++;
        ni += (sample_i_en === 1'b1);
        nq += (sample_q_en === 1'b1);
        if ((bvalid & bready) === 1'b1)
            check(bresp, exp_b.pop_front());
        if ((rvalid & rready) === 1'b1)
            ent = exp_r.pop_front();
        if ((rvalid & rready) === 1'b1)
            check(ent[34] ? rdata : ent[31:0], ent[31:0]);
        if ((rvalid & rready) === 1'b1)
            check(rresp, ent[33:32]);
        since = aresetn ? since + 1 : 0;
        if (cal_running_flag === 1'b1 && run_len == 0)
            rise_cyc = since;
        if (cal_running_flag === 1'b0 && run_len != 0)
            check(run_len, C_RUN);
        run_len = (cal_running_flag === 1'b1) ? run_len + 1 : 0;
        if (cyc > 6000)
            err_count++;
        if (cyc > 6000)
            give_verdict;
    end

    // ==========================================
    // main sequence
    initial
    begin
        {err_count, n_compared, cyc, since, run_len, rise_cyc} = '0;
        seed = 32'h438b;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        for (k = 0; k < 4; k++)
        begin
            aresetn <= 1'b0;
            range_lvl <= t_rng[k];
            strap_lvl <= t_str[k];
            repeat (5) @(posedge aclk);
            aresetn <= 1'b1;
            wait_run(1'b1);
            wait_run(1'b0);
            rise_at[k] = rise_cyc;
            check({ext_ctrl_mode, des_mode, cal_delay_select, range_high, serial_chip_select}, t_exp[k]);
            axi_rd(`OFS_STATUS, {t_exp[k][0], 1'b0, t_exp[k][1], t_exp[k][2], t_exp[k][3], t_exp[k][4]}, `RESP_OKAY, 1'b1);
            ni = 0;
            nq = 0;
            u_board.run_clock(3);
            repeat (10) @(posedge aclk);
            check(ni, t_exp[k][3] ? 6 : 3);
            check(nq, t_exp[k][3] ? 0 : 3);
        end
        check(rise_at[0] - rise_at[3], D_LONG - D_SHORT);
        // extended mode: mask, software start, read-clear, unmapped places
        axi_rd(`OFS_IRQ_STAT, 32'h3, `RESP_OKAY, 1'b1);
        rnd = $random(seed);
        axi_wr(`OFS_IRQ_MASK, rnd, `RESP_OKAY);
        axi_rd(`OFS_IRQ_MASK, {29'h0, rnd[2:0]}, `RESP_OKAY, 1'b1);
        axi_wr(`OFS_IRQ_MASK, 32'h3, `RESP_OKAY);
        axi_wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
        wait_run(1'b1);
        wait_run(1'b0);
        check(irq, 1'b1);
        axi_rd(`OFS_IRQ_STAT, 32'h3, `RESP_OKAY, 1'b1);
        @(negedge aclk);
        check(irq, 1'b0);
        axi_rd(`OFS_IRQ_STAT, 32'h0, `RESP_OKAY, 1'b1);
        axi_rd(8'h10, 32'h0, `RESP_SLVERR, 1'b0);
        axi_wr(8'h14, 32'h0, `RESP_SLVERR);
        // trigger one cycle short of the low minimum, then exactly the minimum
        u_board.pulse_trigger(C_LOW - 1, C_HIGH);
        repeat (20) @(negedge aclk);
        check(run_len, 0);
        axi_rd(`OFS_IRQ_STAT, 32'h0, `RESP_OKAY, 1'b1);
        @(posedge aclk);
        u_board.pulse_trigger(C_LOW, C_HIGH);
        wait_run(1'b1);
        wait_run(1'b0);
        // strap moves after boot: chip select follows, frozen flags do not
        axi_wr(`OFS_IRQ_MASK, 32'h4, `RESP_OKAY);
        strap_lvl <= strap_pkg::LVL_LOW;
        repeat (6) @(negedge aclk);
        check({serial_chip_select, cal_delay_select, des_mode, irq}, 4'b1001);
        give_verdict;
    end
endmodule
